// file: rtl/dpit_pkg.sv
// Package for the dual periodic interval timer: map, fields, counts
package dpit_pkg;
	// Register byte addresses; the printed offsets are not multiples of four,
	// so each offset is kept as an index and the byte address is four times it
	localparam logic [15:0] DPIT_IDX_CONTROL = 16'hFE3C;
	localparam logic [15:0] DPIT_IDX_PERIOD1 = 16'hFE3E;
	localparam logic [15:0] DPIT_IDX_PERIOD2 = 16'hFE3F;
	localparam int          DPIT_AW          = 18;
	localparam logic [17:0] DPIT_ADDR_CONTROL = {DPIT_IDX_CONTROL, 2'b00};
	localparam logic [17:0] DPIT_ADDR_PERIOD1 = {DPIT_IDX_PERIOD1, 2'b00};
	localparam logic [17:0] DPIT_ADDR_PERIOD2 = {DPIT_IDX_PERIOD2, 2'b00};

	// Reset values
	localparam logic [7:0] DPIT_CONTROL_RST = 8'h00;
	localparam logic [7:0] DPIT_PERIOD_RST  = 8'h00;

	// Control field positions
	localparam int DPIT_B_IE1   = 0;
	localparam int DPIT_B_OV1   = 1;
	localparam int DPIT_B_IE2   = 2;
	localparam int DPIT_B_OV2   = 3;
	localparam int DPIT_B_SEL1  = 4;
	localparam int DPIT_B_SEL2  = 6;

	// Clock select encodings
	localparam logic [1:0] DPIT_SEL_STOP = 2'b00;
	localparam logic [1:0] DPIT_SEL_4    = 2'b01;
	localparam logic [1:0] DPIT_SEL_16   = 2'b10;
	localparam logic [1:0] DPIT_SEL_64   = 2'b11;

	// Prescaler terminal counts (divide minus one)
	localparam logic [5:0] DPIT_TC_4  = 6'h03;
	localparam logic [5:0] DPIT_TC_16 = 6'h0F;
	localparam logic [5:0] DPIT_TC_64 = 6'h3F;
endpackage

// file: rtl/dpit_prescaler.sv
// Prescaler: 6-bit divider giving one tick per 4, 16 or 64 cycles
`timescale 1ns/1ps
module dpit_prescaler
	import dpit_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       resetn_i,
	// Control
	input  wire logic [1:0] sel_i,
	input  wire logic       clear_i,
	// Tick out
	output logic            tick_o
);
	import dpit_pkg::*;

	logic [5:0] cnt_r;
	logic [5:0] cnt_nxt;
	logic [5:0] tc;
	logic       hit;

	// Terminal count from select
	assign tc = (sel_i == DPIT_SEL_4)  ? DPIT_TC_4 :
	            (sel_i == DPIT_SEL_16) ? DPIT_TC_16 : DPIT_TC_64;
	assign hit     = (sel_i != DPIT_SEL_STOP) && (cnt_r == tc);
	// Stop select or period write holds divider at zero
	assign cnt_nxt = (clear_i || sel_i == DPIT_SEL_STOP || hit) ? 6'h00 :
	                 cnt_r + 6'h01;
	assign tick_o  = hit && !clear_i;

	// Divider state
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r <= 6'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule // dpit_prescaler

// file: rtl/dpit_counter.sv
// Counter: 8-bit period counter with wrap-on-next-tick overflow
`timescale 1ns/1ps
module dpit_counter
	import dpit_pkg::*;
#(
	parameter int WIDTH = 8
)(
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             resetn_i,
	// Control
	input  wire logic             run_i,
	input  wire logic             clear_i,
	input  wire logic             tick_i,
	input  wire logic [WIDTH-1:0] period_i,
	// Event out
	output logic                  ovf_o
);
	import dpit_pkg::*;

	// Elaboration check; WIDTH may be 1 to 16 bits, the top uses one byte
	if (WIDTH < 1 || WIDTH > 16) begin : g_width_bad
		$error("dpit_counter: WIDTH out of range");
	end

	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] cnt_nxt;
	logic             match;

	// Wrap happens on the tick after the match, so period is R+1 ticks
	assign match   = (cnt_r == period_i);
	assign ovf_o   = run_i && !clear_i && tick_i && match;
	assign cnt_nxt = (!run_i || clear_i) ? '0 :
	                 (tick_i && match) ? '0 :
	                 tick_i ? cnt_r + 1'b1 : cnt_r;

	// Count register
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule // dpit_counter

// file: rtl/dpit_top.sv
// Top: APB slave, control and period registers, two timers, shared irq
`timescale 1ns/1ps
module dpit_top
	import dpit_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_sys_i,
	input  wire logic                resetn_i,
	// APB slave
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [31:0]         paddr_i,
	input  wire logic [31:0]         pwdata_i,
	input  wire logic [3:0]          pstrb_i,
	output logic                     pready_o,
	output logic [31:0]              prdata_o,
	output logic                     pslverr_o,
	// Shared interrupt request
	output logic                     irq_o
);
	import dpit_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Registers and wires
	logic [7:0]  timer_pair_control_r;
	logic [7:0]  timer_pair_control_nxt;
	logic [7:0]  first_timer_period_r;
	logic [7:0]  second_timer_period_r;
	logic        pready_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic        irq_r;

	logic        setup;
	logic        access;
	logic        wr_en;
	logic        rd_en;
	logic        lane0;
	logic        hit_ctl;
	logic        hit_p1;
	logic        hit_p2;
	logic        mapped;
	logic [7:0]  rd_byte;
	logic [1:0]  first_sel;
	logic [1:0]  second_sel;
	logic        first_run;
	logic        second_run;
	logic        first_clear;
	logic        second_clear;
	logic        first_tick;
	logic        second_tick;
	logic        first_ovf;
	logic        second_ovf;
	logic [7:0]  ctl_wr;
	logic        irq_nxt;

	////////////////////////////////////////////////////////////////////////
	// APB decode; no wait state, the answer is registered from the setup cycle.
	// Writes land on the completing edge, never on the setup edge
	assign setup   = psel_i && !penable_i;
	assign access  = psel_i && penable_i && pready_r;
	assign wr_en   = access && pwrite_i;
	assign rd_en   = setup && !pwrite_i;
	assign lane0   = pstrb_i[0];
	assign hit_ctl = (paddr_i[DPIT_AW-1:0] == DPIT_ADDR_CONTROL) &&
	                 (paddr_i[31:DPIT_AW] == '0);
	assign hit_p1  = (paddr_i[DPIT_AW-1:0] == DPIT_ADDR_PERIOD1) &&
	                 (paddr_i[31:DPIT_AW] == '0);
	assign hit_p2  = (paddr_i[DPIT_AW-1:0] == DPIT_ADDR_PERIOD2) &&
	                 (paddr_i[31:DPIT_AW] == '0);
	assign mapped  = hit_ctl || hit_p1 || hit_p2;

	// Read mux; narrow registers sit in the low byte
	assign rd_byte = hit_ctl ? timer_pair_control_r :
	                 hit_p1  ? first_timer_period_r :
	                 hit_p2  ? second_timer_period_r : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Timer control decode
	assign first_sel  = timer_pair_control_r[DPIT_B_SEL1 +: 2];
	assign second_sel = timer_pair_control_r[DPIT_B_SEL2 +: 2];
	assign first_run  = (first_sel != DPIT_SEL_STOP);
	assign second_run = (second_sel != DPIT_SEL_STOP);
	// Period write restarts only while running; stopped timer is zero anyway
	assign first_clear  = wr_en && lane0 && hit_p1 && first_run;
	assign second_clear = wr_en && lane0 && hit_p2 && second_run;

	////////////////////////////////////////////////////////////////////////
	// Two timers, each a prescaler feeding a period counter
	dpit_prescaler u_first_prescaler (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.sel_i     (first_sel),
		.clear_i   (first_clear),
		.tick_o    (first_tick)
	);

	dpit_counter #(.WIDTH(8)) u_first_counter (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.run_i     (first_run),
		.clear_i   (first_clear),
		.tick_i    (first_tick),
		.period_i  (first_timer_period_r),
		.ovf_o     (first_ovf)
	);

	dpit_prescaler u_second_prescaler (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.sel_i     (second_sel),
		.clear_i   (second_clear),
		.tick_o    (second_tick)
	);

	dpit_counter #(.WIDTH(8)) u_second_counter (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.run_i     (second_run),
		.clear_i   (second_clear),
		.tick_i    (second_tick),
		.period_i  (second_timer_period_r),
		.ovf_o     (second_ovf)
	);

	////////////////////////////////////////////////////////////////////////
	// Control next value: software write, then hardware sets on top
	assign ctl_wr = (wr_en && lane0 && hit_ctl) ? pwdata_i[7:0] :
	                timer_pair_control_r;
	assign timer_pair_control_nxt = ctl_wr |
		({7'h00, first_ovf} << DPIT_B_OV1) |
		({7'h00, second_ovf} << DPIT_B_OV2);

	// Shared request from either enabled flag
	assign irq_nxt =
		(timer_pair_control_nxt[DPIT_B_IE1] &&
		 timer_pair_control_nxt[DPIT_B_OV1]) ||
		(timer_pair_control_nxt[DPIT_B_IE2] &&
		 timer_pair_control_nxt[DPIT_B_OV2]);

	////////////////////////////////////////////////////////////////////////
	// Register file
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			timer_pair_control_r  <= DPIT_CONTROL_RST;
			first_timer_period_r  <= DPIT_PERIOD_RST;
			second_timer_period_r <= DPIT_PERIOD_RST;
		end else begin
			timer_pair_control_r <= timer_pair_control_nxt;
			if (wr_en && lane0 && hit_p1) begin
				first_timer_period_r <= pwdata_i[7:0];
			end
			if (wr_en && lane0 && hit_p2) begin
				second_timer_period_r <= pwdata_i[7:0];
			end
		end
	end

	// Interrupt output flop
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// APB answer: pready one cycle after setup, for one cycle
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup && !mapped;
			prdata_r  <= rd_en ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	assign pready_o  = pready_r;
	assign prdata_o  = prdata_r;
	assign pslverr_o = pslverr_r;
	assign irq_o     = irq_r;
endmodule // dpit_top

// file: bench/dpit_checker.sv
// Checker: bus answer timing and irq cause at the timer block ports
`timescale 1ns/1ps
module dpit_checker
	import dpit_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        resetn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	input  wire logic        pready_o,
	input  wire logic [31:0] prdata_o,
	input  wire logic        pslverr_o,
	input  wire logic        irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// Decode of the request as the slave sees it at its setup edge; ctl_wr_w is a control write at its completing edge
	wire setup_w = psel_i && !penable_i;
	wire hit_w = paddr_i == {14'h0, DPIT_ADDR_CONTROL} ||
		paddr_i == {14'h0, DPIT_ADDR_PERIOD1} ||
		paddr_i == {14'h0, DPIT_ADDR_PERIOD2};
	wire ctl_wr_w = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] &&
		paddr_i == {14'h0, DPIT_ADDR_CONTROL};
	sequence s_setup;
		setup_w;
	endsequence
	sequence s_ack;
		pready_o ##1 !pready_o;
	endsequence
	////////////////////////////////////////////////////////////////////
	property p_ready; s_setup |=> s_ack; endproperty
	property p_cause; $rose(pready_o) |-> $past(setup_w); endproperty
	property p_idle; !pready_o |-> prdata_o == 0 && !pslverr_o; endproperty
	property p_err; setup_w && !hit_w |=> pslverr_o && prdata_o == 0;
	endproperty
	property p_ok; setup_w && hit_w |=> !pslverr_o; endproperty
	property p_off; ctl_wr_w && !pwdata_i[0] && !pwdata_i[2] |=> !irq_o;
	endproperty
	property p_irq1; ctl_wr_w && pwdata_i[1:0] == 2'b11 |=> irq_o; endproperty
	property p_irq2; ctl_wr_w && pwdata_i[3:2] == 2'b11 |=> irq_o; endproperty
	a_ready: assert property (p_ready) else $error("no single ready");
	a_cause: assert property (p_cause) else $error("ready without setup");
	a_idle: assert property (p_idle) else $error("idle data not zero");
	a_err: assert property (p_err) else $error("unmapped not refused");
	a_ok: assert property (p_ok) else $error("mapped refused");
	a_off: assert property (p_off) else $error("irq with no enable");
	a_irq1: assert property (p_irq1) else $error("first irq missing");
	a_irq2: assert property (p_irq2) else $error("second irq missing");
endmodule // dpit_checker

bind dpit_top dpit_checker dpit_checker_inst (.clk_sys_i, .resetn_i,
	.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
	.pready_o, .prdata_o, .pslverr_o, .irq_o);

// file: bench/tb_top.sv
// Testbench: registers, period timing, restart and stop of both timers
`timescale 1ns/1ps
module tb_top;
	import dpit_pkg::*;
	logic        clk_sys_i, resetn_i, psel_i, penable_i, pwrite_i;
	logic [31:0] paddr_i, pwdata_i, prdata_o;
	logic [3:0]  pstrb_i;
	logic        pready_o, pslverr_o, irq_o, er;
	logic [7:0]  rd;
	int          fail_count, check_count;

	dpit_top dpit_top_inst (.clk_sys_i, .resetn_i, .psel_i, .penable_i,
		.pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pready_o, .prdata_o,
		.pslverr_o, .irq_o);

	// Clock and hang guard
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		#200000;
		fail_count++;
		results();
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask
	// One bus transfer; waits for ready, never assumes its latency
	task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= {14'h0, a};
		pwdata_i <= {24'h0, d};
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		k = 0;
		// Look mid-cycle, where the answer has settled before its edge
		do begin
			@(negedge clk_sys_i);
			k++;
		end while (pready_o !== 1'b1 && k < 50);
		chk("pready", 1'b1, pready_o);
		rd = prdata_o[7:0];
		er = pslverr_o;
		@(posedge clk_sys_i);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	// Edges from a write's return until irq is seen, bounded
	task automatic wait_irq(output int n);
		n = 0;
		do begin
			@(negedge clk_sys_i);
			n++;
		end while (irq_o !== 1'b1 && n < 20000);
	endtask
	task automatic run_period(input int t, input logic [1:0] s,
		input logic [7:0] r);
		logic [7:0] c, f;
		int n;
		c = t ? {s, 6'h04} : {2'b00, s, 4'h1};
		f = t ? 8'h08 : 8'h02;
		apb(1, t ? DPIT_ADDR_PERIOD2 : DPIT_ADDR_PERIOD1, r);
		apb(1, DPIT_ADDR_CONTROL, c);
		wait_irq(n);
		chk("period", (r + 1) * (4 << (2 * (s - 1))) + 1, n);
		apb(0, DPIT_ADDR_CONTROL, 0);
		chk("flag", c | f, rd);
		apb(1, DPIT_ADDR_CONTROL, c | f);
		// Stop with enable kept; flag cleared, nothing may come back
		apb(1, DPIT_ADDR_CONTROL, t ? 8'h04 : 8'h01);
		repeat (300) @(posedge clk_sys_i);
		chk("stopped irq", 0, irq_o);
		apb(0, DPIT_ADDR_CONTROL, 0);
		chk("cleared", t ? 8'h04 : 8'h01, rd);
	endtask
	task automatic restart(input int t);
		int n;
		apb(1, t ? DPIT_ADDR_PERIOD2 : DPIT_ADDR_PERIOD1, 8'h09);
		apb(1, DPIT_ADDR_CONTROL, t ? 8'h44 : 8'h11);
		repeat (25) @(posedge clk_sys_i);
		apb(1, t ? DPIT_ADDR_PERIOD2 : DPIT_ADDR_PERIOD1, 8'h09);
		wait_irq(n);
		chk("restart", 41, n);
		apb(1, DPIT_ADDR_CONTROL, 8'h00);
	endtask
	task automatic results;
		if (fail_count == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		{resetn_i, psel_i, penable_i, pwrite_i} = 4'h0;
		{paddr_i, pwdata_i} = 64'h0;
		pstrb_i = 4'hF;
		repeat (4) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		apb(0, DPIT_ADDR_CONTROL, 0);
		chk("control reset", DPIT_CONTROL_RST, rd);
		apb(0, DPIT_ADDR_PERIOD1, 0);
		chk("period1 reset", DPIT_PERIOD_RST, rd);
		apb(0, DPIT_ADDR_PERIOD2, 0);
		chk("period2 reset", DPIT_PERIOD_RST, rd);
		apb(0, 18'h00010, 0);
		chk("unmapped", 1'b1, er);
		for (int t = 0; t < 2; t++) begin
			run_period(t, DPIT_SEL_4, 8'hFF);
			run_period(t, DPIT_SEL_16, 8'h00);
			run_period(t, DPIT_SEL_64, 8'h03);
			restart(t);
		end
		results();
	end
endmodule // tb_top
